// ---- hw/gxp_core.v ----
// What this block does
// - Pin-state read gives pin level, optionally inverted
// - Pin-state read clears that bank's pending interrupts
// - Output pins read back last output-level value
// - Writes to pin-state registers are ignored
// - Bit 7..0 map pins 7..0 or 15..8
// - Output-level drives outputs, reads back written value
// - Invert bit one shows inverted input level
// - Direction zero is output, one is input
// - All direction bits reset to one
// - Pull-up enable one turns on input pull-up
// - Interrupt enable allows interrupts, resets cleared
// - Output pins never raise interrupts
// - Three-state bit one floats the output pin
// - Status registers show pending pins, read-only
// - Rise enable raises interrupt on rising edge
// - Fall enable raises interrupt on falling edge
// - Filter enables reset to all ones
// - Filter passes long levels, rejects short pulses
// - Filter bit zero bypasses the filter
// - No edge bits: any edge, clears on return
// - Edge bits set: cleared only by read
`include "gxp_regs.vh"

module gxp_core (
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        rst_i,
    // Register port from the serial slave
    input  wire [7:0]  reg_addr_i,
    input  wire        reg_wr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_rd_i,
    output wire [7:0]  reg_rdata_o,
    output wire        reg_rvalid_o,
    // GPIO pins
    input  wire [15:0] pin_in_i,
    output wire [15:0] pin_out_o,
    output wire [15:0] pin_oe_n_o,
    output wire [15:0] pin_pullup_o,
    // Interrupt
    output wire        irq_n_o
);

    // Filter hold in clock cycles; 500 ns leaves margin on both
    // sides of the reject and pass limits
    localparam integer FLT_LIM = `GXP_FLT_CYC;

    // Merge a byte into the selected bank of a 16-bit pair
    // hi picks the upper byte; the other bank keeps its value
    function [15:0] bank_wr;
        input [15:0] cur;
        input [7:0]  data;
        input        hi;
        begin
            if (hi) begin
                bank_wr = {data, cur[7:0]};
            end else begin
                bank_wr = {cur[15:8], data};
            end
        end
    endfunction

    // Select one bank of a 16-bit pair
    // Shared by every read case so the bank order lives in one place
    function [7:0] bank_rd;
        input [15:0] v;
        input        hi;
        begin
            if (hi) begin
                bank_rd = v[15:8];
            end else begin
                bank_rd = v[7:0];
            end
        end
    endfunction

    // Configuration registers, {high bank, low bank}
    // Kept as 16-bit pairs so bit n is always pin n inside the core
    reg [15:0] olvl_r;
    reg [15:0] inv_r;
    reg [15:0] dir_r;
    reg [15:0] pu_r;
    reg [15:0] ien_r;
    reg [15:0] hiz_r;
    reg [15:0] ren_r;
    reg [15:0] fen_r;
    reg [15:0] flt_en_r;

    // Pin sampling and interrupt state
    // One hold counter per pin, so pins never share a count
    reg [15:0] sync1_r;
    reg [15:0] sync2_r;
    reg [15:0] filt_r;
    reg [15:0] prev_r;
    reg [15:0] snap_r;
    reg [15:0] snap_nxt;
    reg [15:0] stat_r;
    reg [15:0] stat_nxt;
    reg [`GXP_FLT_CNT_W-1:0] cnt_r [0:15];

    // Output flops
    // Every port is a flop so pin drivers see no decode glitches
    reg [7:0]  rdata_r;
    reg        rvalid_r;
    reg [15:0] oe_n_r;
    reg [15:0] pull_r;
    reg        irq_n_r;

    // Decode helpers
    // Scratch values of the status loop, set afresh on every pass
    reg [15:0] rd_mask;
    reg        act;
    reg        setb;
    reg        clrb;
    reg        rise;
    reg        fall;
    integer    i;
    integer    j;

    // Odd offsets address the high bank
    wire        hi_sel = reg_addr_i[0];
    wire [15:0] eff;
    wire [15:0] pin_state;

    // Filtered level where enabled, raw synced level otherwise
    // Edge detection follows eff, so a filtered pin only shows
    // levels that held for the whole hold count
    assign eff = (flt_en_r & filt_r) | (~flt_en_r & sync2_r);

    // Inputs show pin level (inverted on request), outputs the latch
    // Raw synced level, not filtered: a read shows the pin as it is
    // Limitation: a change younger than two cycles is not yet seen
    assign pin_state = (dir_r & (sync2_r ^ inv_r))
                     | (~dir_r & olvl_r);

    // Register writes; pin-state and status offsets fall through
    // Read-only offsets have no case item, so a write to them
    // cannot touch any state by accident
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            // All pins inputs and filtered straight out of reset
            olvl_r   <= `GXP_RST_OUTPUT_LEVEL;
            inv_r    <= `GXP_RST_INPUT_INVERT;
            dir_r    <= `GXP_RST_DIRECTION;
            pu_r     <= `GXP_RST_PULLUP_ENABLE;
            ien_r    <= `GXP_RST_IRQ_ENABLE;
            hiz_r    <= `GXP_RST_HIZ_CONTROL;
            ren_r    <= `GXP_RST_RISE_ENABLE;
            fen_r    <= `GXP_RST_FALL_ENABLE;
            flt_en_r <= `GXP_RST_GLITCH_FILTER;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `GXP_OFF_OUTPUT_LEVEL_LOW,
                `GXP_OFF_OUTPUT_LEVEL_HIGH: begin
                    olvl_r <= bank_wr(olvl_r, reg_wdata_i, hi_sel);
                end
                `GXP_OFF_INPUT_INVERT_LOW,
                `GXP_OFF_INPUT_INVERT_HIGH: begin
                    inv_r <= bank_wr(inv_r, reg_wdata_i, hi_sel);
                end
                `GXP_OFF_DIRECTION_LOW,
                `GXP_OFF_DIRECTION_HIGH: begin
                    dir_r <= bank_wr(dir_r, reg_wdata_i, hi_sel);
                end
                `GXP_OFF_PULLUP_ENABLE_LOW,
                `GXP_OFF_PULLUP_ENABLE_HIGH: begin
                    pu_r <= bank_wr(pu_r, reg_wdata_i, hi_sel);
                end
                `GXP_OFF_IRQ_ENABLE_LOW,
                `GXP_OFF_IRQ_ENABLE_HIGH: begin
                    ien_r <= bank_wr(ien_r, reg_wdata_i, hi_sel);
                end
                `GXP_OFF_HIZ_CONTROL_LOW,
                `GXP_OFF_HIZ_CONTROL_HIGH: begin
                    hiz_r <= bank_wr(hiz_r, reg_wdata_i, hi_sel);
                end
                `GXP_OFF_RISE_ENABLE_LOW,
                `GXP_OFF_RISE_ENABLE_HIGH: begin
                    ren_r <= bank_wr(ren_r, reg_wdata_i, hi_sel);
                end
                `GXP_OFF_FALL_ENABLE_LOW,
                `GXP_OFF_FALL_ENABLE_HIGH: begin
                    fen_r <= bank_wr(fen_r, reg_wdata_i, hi_sel);
                end
                `GXP_OFF_GLITCH_FILTER_LOW,
                `GXP_OFF_GLITCH_FILTER_HIGH: begin
                    flt_en_r <= bank_wr(flt_en_r, reg_wdata_i, hi_sel);
                end
                default: begin
                    // Pin-state, status and unmapped: no effect
                end
            endcase
        end
    end

    // Read data, registered one cycle after the strobe
    // Reading status does not clear it; only a pin-state read does
    // rvalid is a plain one-cycle echo of the strobe
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd_i;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `GXP_OFF_PIN_STATE_LOW,
                    `GXP_OFF_PIN_STATE_HIGH:
                        rdata_r <= bank_rd(pin_state, hi_sel);
                    `GXP_OFF_OUTPUT_LEVEL_LOW,
                    `GXP_OFF_OUTPUT_LEVEL_HIGH:
                        rdata_r <= bank_rd(olvl_r, hi_sel);
                    `GXP_OFF_INPUT_INVERT_LOW,
                    `GXP_OFF_INPUT_INVERT_HIGH:
                        rdata_r <= bank_rd(inv_r, hi_sel);
                    `GXP_OFF_DIRECTION_LOW,
                    `GXP_OFF_DIRECTION_HIGH:
                        rdata_r <= bank_rd(dir_r, hi_sel);
                    `GXP_OFF_PULLUP_ENABLE_LOW,
                    `GXP_OFF_PULLUP_ENABLE_HIGH:
                        rdata_r <= bank_rd(pu_r, hi_sel);
                    `GXP_OFF_IRQ_ENABLE_LOW,
                    `GXP_OFF_IRQ_ENABLE_HIGH:
                        rdata_r <= bank_rd(ien_r, hi_sel);
                    `GXP_OFF_HIZ_CONTROL_LOW,
                    `GXP_OFF_HIZ_CONTROL_HIGH:
                        rdata_r <= bank_rd(hiz_r, hi_sel);
                    `GXP_OFF_IRQ_STATUS_LOW,
                    `GXP_OFF_IRQ_STATUS_HIGH:
                        rdata_r <= bank_rd(stat_r, hi_sel);
                    `GXP_OFF_RISE_ENABLE_LOW,
                    `GXP_OFF_RISE_ENABLE_HIGH:
                        rdata_r <= bank_rd(ren_r, hi_sel);
                    `GXP_OFF_FALL_ENABLE_LOW,
                    `GXP_OFF_FALL_ENABLE_HIGH:
                        rdata_r <= bank_rd(fen_r, hi_sel);
                    `GXP_OFF_GLITCH_FILTER_LOW,
                    `GXP_OFF_GLITCH_FILTER_HIGH:
                        rdata_r <= bank_rd(flt_en_r, hi_sel);
                    default:
                        // Unmapped offsets read as zero
                        rdata_r <= 8'h00;
                endcase
            end
        end
    end

    // Two-stage synchroniser, then per-pin hold counter
    // Hold of 500 ns sits well inside the 225/1075 ns window
    // A pin that flips back before the count runs out restarts it,
    // so a burst of short glitches can never add up to a pass
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            // Start low; a high pin settles within one hold count,
            // while interrupts are still disabled
            sync1_r <= 16'h0000;
            sync2_r <= 16'h0000;
            filt_r  <= 16'h0000;
            prev_r  <= 16'h0000;
            for (i = 0; i < 16; i = i + 1) begin
                cnt_r[i] <= {`GXP_FLT_CNT_W{1'b0}};
            end
        end else begin
            sync1_r <= pin_in_i;
            sync2_r <= sync1_r;
            prev_r  <= eff;
            for (i = 0; i < 16; i = i + 1) begin
                if (!flt_en_r[i] || sync2_r[i] == filt_r[i]) begin
                    // Bypassed pins track so re-enabling is glitch free
                    filt_r[i] <= sync2_r[i];
                    cnt_r[i]  <= {`GXP_FLT_CNT_W{1'b0}};
                end else if (cnt_r[i] ==
                             FLT_LIM[`GXP_FLT_CNT_W-1:0] - 8'h01) begin
                    // New level held for the whole hold time
                    filt_r[i] <= sync2_r[i];
                    cnt_r[i]  <= {`GXP_FLT_CNT_W{1'b0}};
                end else begin
                    cnt_r[i] <= cnt_r[i] + 8'h01;
                end
            end
        end
    end

    // Interrupt status next state; a set beats a clear
    // Own loop index, so no variable is driven from two processes
    always @* begin
        stat_nxt = stat_r;
        snap_nxt = snap_r;
        rd_mask  = 16'h0000;
        act      = 1'b0;
        setb     = 1'b0;
        clrb     = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `GXP_OFF_PIN_STATE_LOW: begin
                    rd_mask = `GXP_MASK_LOW;
                end
                `GXP_OFF_PIN_STATE_HIGH: begin
                    rd_mask = `GXP_MASK_HIGH;
                end
                default: begin
                    rd_mask = 16'h0000;
                end
            endcase
        end
        for (j = 0; j < 16; j = j + 1) begin
            act  = dir_r[j] & ien_r[j];
            // Edge of the level the interrupt logic sees
            rise = eff[j] & ~prev_r[j];
            fall = ~eff[j] & prev_r[j];
            if (ren_r[j] | fen_r[j]) begin
                // Edge bits given: only a pin-state read clears
                setb = (ren_r[j] & rise)
                     | (fen_r[j] & fall);
                clrb = rd_mask[j];
            end else begin
                // No edge bits: a return to the snapshot clears too
                setb = rise | fall;
                clrb = rd_mask[j] | (eff[j] == snap_r[j]);
            end
            // Output or disabled pins are held clear; otherwise an
            // edge in the same cycle as a clear is kept, not lost
            if (!act) begin
                stat_nxt[j] = 1'b0;
            end else if (setb) begin
                stat_nxt[j] = 1'b1;
            end else if (clrb) begin
                stat_nxt[j] = 1'b0;
            end
            // Snapshot follows every pin-state read of its bank
            if (rd_mask[j]) begin
                snap_nxt[j] = eff[j];
            end
        end
    end

    // Status, snapshot and pin drive flops
    // oe_n and pull-up lag the registers by one cycle; harmless at
    // pin speeds, and it keeps every output on a flop
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            stat_r  <= 16'h0000;
            snap_r  <= 16'h0000;
            oe_n_r  <= 16'hFFFF;
            pull_r  <= 16'h0000;
            irq_n_r <= 1'b1;
        end else begin
            stat_r  <= stat_nxt;
            snap_r  <= snap_nxt;
            oe_n_r  <= dir_r | hiz_r;
            // Pull-up only on inputs, never loading a driven pin
            pull_r  <= pu_r & dir_r;
            // From the next status, so irq_n moves with the status
            irq_n_r <= ~(|stat_nxt);
        end
    end

    // Ports straight from their flops
    assign reg_rdata_o  = rdata_r;
    assign reg_rvalid_o = rvalid_r;
    assign pin_out_o    = olvl_r;
    assign pin_oe_n_o   = oe_n_r;
    assign pin_pullup_o = pull_r;
    assign irq_n_o      = irq_n_r;

endmodule

// ---- hw/gxp_regs.vh ----
`ifndef GXP_REGS_VH
`define GXP_REGS_VH

// Command byte offsets, low bank then high bank
`define GXP_OFF_PIN_STATE_LOW      8'h00
`define GXP_OFF_PIN_STATE_HIGH     8'h01
`define GXP_OFF_OUTPUT_LEVEL_LOW   8'h02
`define GXP_OFF_OUTPUT_LEVEL_HIGH  8'h03
`define GXP_OFF_INPUT_INVERT_LOW   8'h04
`define GXP_OFF_INPUT_INVERT_HIGH  8'h05
`define GXP_OFF_DIRECTION_LOW      8'h06
`define GXP_OFF_DIRECTION_HIGH     8'h07
`define GXP_OFF_PULLUP_ENABLE_LOW  8'h08
`define GXP_OFF_PULLUP_ENABLE_HIGH 8'h09
`define GXP_OFF_IRQ_ENABLE_LOW     8'h0A
`define GXP_OFF_IRQ_ENABLE_HIGH    8'h0B
`define GXP_OFF_HIZ_CONTROL_LOW    8'h0C
`define GXP_OFF_HIZ_CONTROL_HIGH   8'h0D
`define GXP_OFF_IRQ_STATUS_LOW     8'h0E
`define GXP_OFF_IRQ_STATUS_HIGH    8'h0F
`define GXP_OFF_RISE_ENABLE_LOW    8'h10
`define GXP_OFF_RISE_ENABLE_HIGH   8'h11
`define GXP_OFF_FALL_ENABLE_LOW    8'h12
`define GXP_OFF_FALL_ENABLE_HIGH   8'h13
`define GXP_OFF_GLITCH_FILTER_LOW  8'h14
`define GXP_OFF_GLITCH_FILTER_HIGH 8'h15

// Reset values, both banks together
`define GXP_RST_OUTPUT_LEVEL   16'hFFFF
`define GXP_RST_INPUT_INVERT   16'h0000
`define GXP_RST_DIRECTION      16'hFFFF
`define GXP_RST_PULLUP_ENABLE  16'h0000
`define GXP_RST_IRQ_ENABLE     16'h0000
`define GXP_RST_HIZ_CONTROL    16'h0000
`define GXP_RST_RISE_ENABLE    16'h0000
`define GXP_RST_FALL_ENABLE    16'h0000
`define GXP_RST_GLITCH_FILTER  16'hFFFF

// Bank masks: low bank is pins 7..0, high bank pins 15..8
`define GXP_MASK_LOW   16'h00FF
`define GXP_MASK_HIGH  16'hFF00

// Glitch filter timing
`define GXP_CLK_MHZ         200
`define GXP_FLT_PASS_NS     1075
`define GXP_FLT_REJECT_NS   225
`define GXP_FLT_HOLD_NS     500
`define GXP_FLT_CYC  ((`GXP_FLT_HOLD_NS * `GXP_CLK_MHZ) / 1000)
`define GXP_FLT_CNT_W       8

`endif

// ---- verif/gxp_core_monitor.sv ----
module gxp_core_monitor (
    // Clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    // Register port
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        reg_rvalid_o,
    // Pins and interrupt
    input wire logic [15:0] pin_in_i,
    input wire logic [15:0] pin_out_o,
    input wire logic [15:0] pin_oe_n_o,
    input wire logic [15:0] pin_pullup_o,
    input wire logic        irq_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // One write strobe aimed at a given offset
    sequence s_wr(logic [7:0] a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    // Status read whose answer shows a pending pin
    sequence s_status_hit;
        reg_rd_i && reg_addr_i inside {8'h0E, 8'h0F} ##1 reg_rdata_o != 8'h00;
    endsequence

    a_read_answer: assert property (reg_rvalid_o == $past(reg_rd_i))
        else $error("read answer strobe out of step");
    a_reset_state: assert property (disable iff (1'b0) rst_i |=>
        pin_oe_n_o == 16'hFFFF && pin_out_o == 16'hFFFF && irq_n_o)
        else $error("outputs not at reset state");
    a_level_low: assert property (s_wr(8'h02) |=>
        pin_out_o[7:0] == $past(reg_wdata_i))
        else $error("low output level not driven");
    a_level_high: assert property (s_wr(8'h03) |=>
        pin_out_o[15:8] == $past(reg_wdata_i))
        else $error("high output level not driven");
    a_state_wr_ignored: assert property (
        reg_wr_i && reg_addr_i <= 8'h01 |=> $stable(pin_out_o))
        else $error("pin state write changed outputs");
    a_dir_input_oe: assert property (
        s_wr(8'h06) ##0 reg_wdata_i == 8'hFF |-> ##2 pin_oe_n_o[7:0] == 8'hFF)
        else $error("input pins still driven");
    a_out_readback: assert property (reg_rd_i && reg_addr_i == 8'h00 &&
        pin_oe_n_o[7:0] == 8'h00 && !$past(reg_wr_i)
        |=> reg_rdata_o == $past(pin_out_o[7:0]))
        else $error("output pins read wrong state");
    a_irq_pending: assert property (s_status_hit |-> !$past(irq_n_o))
        else $error("pending status without interrupt");
endmodule

bind gxp_core gxp_core_monitor u_mon (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
    .pin_pullup_o(pin_pullup_o), .irq_n_o(irq_n_o));

// ---- verif/gxp_host.sv ----
module gxp_host (
    // Clock
    input wire logic        sys_clk_i,
    // Strobe port toward the core
    output logic [7:0]      reg_addr_o,
    output logic            reg_wr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_rd_o,
    input wire logic [7:0]  reg_rdata_i,
    input wire logic        reg_rvalid_i
);
    timeunit 1ns;
    timeprecision 100ps;
    int gap = 0; // Idle cycles before each request, for a slow host

    // Idle bus at time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end

    // Command byte picks the register of each strobe
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic ok);
        int i;
        repeat (gap + 1) @(posedge sys_clk_i);
        #1;
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = w;
        reg_rd_o = !w;
        @(posedge sys_clk_i) #1;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        // Released lines do not keep their last value
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
        for (i = 0; i < 4 && !w && reg_rvalid_i !== 1'b1; i++)
            @(posedge sys_clk_i) #1;
        ok = w || reg_rvalid_i === 1'b1;
        q = reg_rdata_i;
    endtask
endmodule

// ---- verif/tb_gxp_core.sv ----
`define GXP_CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module tb_gxp_core;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [15:0] pin_in_i = 16'h0000;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, q;
    logic        reg_wr_i, reg_rd_i, reg_rvalid_o, irq_n_o, ok;
    logic [15:0] pin_out_o, pin_oe_n_o, pin_pullup_o;
    int          failures = 0;
    int          comparisons = 0;

    always #2.5 sys_clk_i = ~sys_clk_i;

    gxp_core uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
        .pin_oe_n_o(pin_oe_n_o), .pin_pullup_o(pin_pullup_o),
        .irq_n_o(irq_n_o));
    gxp_host host (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i),
        .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o),
        .reg_rvalid_i(reg_rvalid_o));

    // Verdict and end of run, also reached by any expired wait
    task automatic close_out;
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(a, 1'b1, d, q, ok);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.xfer(a, 1'b0, 8'h00, q, ok);
        `GXP_CHK(ok, 1'b1)
        if (!ok) close_out;
        `GXP_CHK(q, e)
    endtask
    // Bounded wait for the interrupt line to reach lvl
    task automatic wait_irq(input logic lvl, input int n);
        int i;
        for (i = 0; i < n && irq_n_o !== lvl; i++)
            @(posedge sys_clk_i) #1;
        `GXP_CHK(irq_n_o, lvl)
        if (irq_n_o !== lvl) close_out;
    endtask
    // Interrupt must still be quiet after n cycles
    task automatic quiet(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
        `GXP_CHK(irq_n_o, 1'b1)
    endtask
    // Low bank as inputs, edge and filter mode, snapshot, then enable
    task automatic cfg(input logic [7:0] r, input logic [7:0] f,
                       input logic [7:0] flt);
        wr(8'h0A, 8'h00);
        wr(8'h06, 8'hFF);
        wr(8'h04, 8'h00);
        wr(8'h10, r);
        wr(8'h12, f);
        wr(8'h14, flt);
        rd_chk(8'h00, pin_in_i[7:0]);
        wr(8'h0A, 8'h01);
    endtask
    function automatic logic [7:0] rst_val(input int a);
        return (a inside {2, 3, 6, 7, 20, 21}) ? 8'hFF : 8'h00;
    endfunction

    initial begin
        repeat (16) @(posedge sys_clk_i);
        #1 rst_i = 1'b0;
        for (int a = 2; a < 22; a++)
            rd_chk(8'(a), rst_val(a));
        // Distinct pattern in every register; status and state refuse it
        for (int a = 2; a < 22; a++)
            wr(8'(a), 8'(8'hA5 ^ a));
        wr(8'h0E, 8'h5A);
        wr(8'h00, 8'h5A);
        for (int a = 2; a < 22; a++)
            rd_chk(8'(a), (a inside {14, 15}) ? 8'h00 : 8'(8'hA5 ^ a));
        rd_chk(8'h16, 8'h00);
        `GXP_CHK(pin_out_o, 16'hA6A7)
        // Inverted and true inputs across both banks
        wr(8'h0B, 8'h00);
        wr(8'h07, 8'hFF);
        wr(8'h05, 8'hF0);
        cfg(8'h00, 8'h00, 8'hFF);
        wr(8'h0A, 8'h00);
        wr(8'h04, 8'h0F);
        pin_in_i = 16'h8001;
        repeat (4) @(posedge sys_clk_i);
        rd_chk(8'h00, 8'h0E);
        rd_chk(8'h01, 8'h70);
        // Output pins read back the level register, even floated
        wr(8'h0A, 8'hFF);
        wr(8'h14, 8'h00);
        wr(8'h02, 8'h3C);
        wr(8'h0C, 8'hFF);
        wr(8'h06, 8'h00);
        pin_in_i[7:0] = 8'hC3;
        quiet(10);
        rd_chk(8'h00, 8'h3C);
        `GXP_CHK(pin_oe_n_o[7:0], 8'hFF)
        `GXP_CHK(pin_pullup_o[7:0], 8'h00)
        wr(8'h0C, 8'h00);
        rd_chk(8'h00, 8'h3C);
        `GXP_CHK(pin_oe_n_o[7:0], 8'h00)
        wr(8'h0A, 8'h00);
        wr(8'h06, 8'hFF);
        pin_in_i[7:0] = 8'h00;
        repeat (2) @(posedge sys_clk_i);
        #1;
        `GXP_CHK(pin_pullup_o[7:0], 8'hAD)
        // Either edge, no filter: return to snapshot clears, so does read
        cfg(8'h00, 8'h00, 8'h00);
        pin_in_i[0] = 1'b1;
        wait_irq(1'b0, 8);
        rd_chk(8'h0E, 8'h01);
        pin_in_i[0] = 1'b0;
        wait_irq(1'b1, 8);
        pin_in_i[0] = 1'b1;
        wait_irq(1'b0, 8);
        rd_chk(8'h00, 8'h01);
        rd_chk(8'h0E, 8'h00);
        wait_irq(1'b1, 2);
        // Rising edge only; return to old level does not clear
        cfg(8'h01, 8'h00, 8'h00);
        pin_in_i[0] = 1'b0;
        quiet(10);
        pin_in_i[0] = 1'b1;
        wait_irq(1'b0, 8);
        pin_in_i[0] = 1'b0;
        repeat (10) @(posedge sys_clk_i);
        #1;
        `GXP_CHK(irq_n_o, 1'b0)
        rd_chk(8'h00, 8'h00);
        wait_irq(1'b1, 2);
        // Falling edge only
        cfg(8'h00, 8'h01, 8'h00);
        pin_in_i[0] = 1'b1;
        quiet(10);
        pin_in_i[0] = 1'b0;
        wait_irq(1'b0, 8);
        rd_chk(8'h0E, 8'h01);
        // Both edge bits: rising edge sets, falling edge keeps it, only a read clears
        cfg(8'h01, 8'h01, 8'h00);
        pin_in_i[0] = 1'b1;
        wait_irq(1'b0, 8);
        pin_in_i[0] = 1'b0;
        repeat (10) @(posedge sys_clk_i);
        #1;
        `GXP_CHK(irq_n_o, 1'b0)
        rd_chk(8'h00, 8'h00);
        wait_irq(1'b1, 2);
        // Filter on: short pulse rejected, long level passes, slow host
        cfg(8'h00, 8'h00, 8'hFF);
        pin_in_i[0] = 1'b1;
        repeat (40) @(posedge sys_clk_i);
        #1 pin_in_i[0] = 1'b0;
        quiet(150);
        pin_in_i[0] = 1'b1;
        quiet(44);
        wait_irq(1'b0, 171);
        host.gap = 3;
        rd_chk(8'h00, 8'h01);
        wait_irq(1'b1, 2);
        // Second reset in mid-run
        host.gap = 0;
        rst_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1 rst_i = 1'b0;
        rd_chk(8'h06, 8'hFF);
        rd_chk(8'h14, 8'hFF);
        close_out;
    end
endmodule
